// ---- src/uft_pkg.sv ----
// Constants and types shared by the FIFO test access block
package uft_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int HWORD_W = 32;
    localparam logic [31:0] ADDR_FCTL = 32'h5000_1108;
    localparam logic [31:0] ADDR_FAR = 32'h5000_1170;
    localparam logic [31:0] ADDR_USR = 32'h5000_117c;
    localparam logic [31:0] ADDR_RX_TEST = 32'h5000_1180;
    localparam logic [31:0] ADDR_TX_TEST = 32'h5000_1184;
    localparam int FAR_EN_BIT = 0;
    localparam int FCTL_EN_BIT = 0;
    localparam int USR_RFF_BIT = 4;
    localparam logic FAR_RESET = 1'h0;
    localparam logic FCTL_RESET = 1'h0;
    localparam logic [CNT_W-1:0] HOLD_CAP = 5'h01;
    localparam logic [CNT_W-1:0] FIFO_CAP = 5'h10;
    localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;
    localparam logic HRESP_OKAY = 1'h0;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} uft_bus_t;
endpackage

// ---- src/uft_fifo.sv ----
// Byte FIFO whose capacity shrinks to one entry in holding mode
`timescale 1ns/1ps
`default_nettype none
module uft_fifo (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [uft_pkg::CNT_W-1:0] cap,
    input wire logic push,
    input wire logic [uft_pkg::DATA_W-1:0] wdata,
    input wire logic pop,
    output logic [uft_pkg::DATA_W-1:0] head,
    output logic [uft_pkg::CNT_W-1:0] count,
    output logic full,
    output logic empty
);
    import uft_pkg::*;
    logic [DATA_W-1:0] mem_r [FIFO_DEPTH];
    logic [CNT_W-2:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    assign full = (cnt_r >= cap);
    assign empty = (cnt_r == '0);
    assign count = cnt_r;
    assign head = mem_r[rp_r];
    // Full drops a push, empty drops a pop
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (clr) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (do_push) wp_nxt = wp_r + 1'b1;
            if (do_pop) rp_nxt = rp_r + 1'b1;
            if (do_push && !do_pop) cnt_nxt = cnt_r + 1'b1;
            if (do_pop && !do_push) cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; pointers define validity
    always_ff @(posedge core_clk) begin
        if (do_push && !clr) mem_r[wp_r] <= wdata;
    end
endmodule
`default_nettype wire

// ---- src/uft_change_det.sv ----
// One-cycle pulse whenever a registered level changes
`timescale 1ns/1ps
`default_nettype none
module uft_change_det (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic level,
    output logic changed
);
    logic prev_r;
    logic prev_nxt;

    assign prev_nxt = level;
    assign changed = level ^ prev_r;

    always_ff @(posedge core_clk) begin
        if (rst) prev_r <= 1'h0;
        else prev_r <= prev_nxt;
    end
endmodule
`default_nettype wire

// ---- src/uft_test_access.sv ----
// FIFO test access block of the UART with its AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Enable bit readable; writes ignored without option
// - Enable on: master fills rx, drains tx
// - FIFOs off: single holding registers used
// - Toggling enable empties both FIFOs
// - Status bit 4 shows rx FIFO full
// - Full bit clears itself when not full
// - Control bit 0 switches FIFO operation
// - Depth 16 sets rx full point with FIFOs on
module uft_test_access #(
    parameter bit FIFO_ACCESS = 1'b1
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [uft_pkg::HWORD_W-1:0] hwdata,
    input wire logic hready,
    output logic [uft_pkg::HWORD_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic core_rx_push,
    input wire logic [uft_pkg::DATA_W-1:0] core_rx_data,
    input wire logic core_rx_pop,
    output logic [uft_pkg::DATA_W-1:0] rx_head_data,
    output logic rx_head_valid,
    input wire logic core_tx_push,
    input wire logic [uft_pkg::DATA_W-1:0] core_tx_data,
    input wire logic core_tx_pop,
    output logic [uft_pkg::DATA_W-1:0] tx_head_data,
    output logic tx_head_valid,
    output logic fifo_enabled,
    output logic test_access_active
);
    import uft_pkg::*;
    uft_bus_t bus_r, bus_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [HWORD_W-1:0] hrdata_r, hrdata_nxt;
    logic hready_r, hready_nxt;
    logic fae_r, fae_nxt;
    logic fctl_en_r, fctl_en_nxt;
    logic [DATA_W-1:0] rxh_r, rxh_nxt, txh_r, txh_nxt;
    logic rxv_r, rxv_nxt, txv_r, txv_nxt;
    logic accept, m_rx_push, m_tx_pop, fae_chg, fctl_chg, clr;
    logic rx_push, rx_pop, tx_push, tx_pop;
    logic [DATA_W-1:0] rx_wdata, rx_head, tx_head;
    logic [CNT_W-1:0] cap, rx_count, tx_count;
    logic rx_full, rx_empty, tx_full, tx_empty;

    // hsize is unused: only whole-word transfers reach this slave
    assign accept = hsel && hready && htrans[1];
    assign cap = fctl_en_r ? FIFO_CAP : HOLD_CAP;

    // Bus state and register updates
    always_comb begin
        bus_nxt = BUS_IDLE;
        addr_nxt = addr_r;
        hready_nxt = 1'b1;
        hrdata_nxt = hrdata_r;
        fae_nxt = fae_r;
        fctl_en_nxt = fctl_en_r;
        m_rx_push = 1'b0;
        m_tx_pop = 1'b0;
        if (bus_r == BUS_WRITE) begin
            if (addr_r == ADDR_FAR && FIFO_ACCESS) begin
                fae_nxt = hwdata[FAR_EN_BIT];
            end
            if (addr_r == ADDR_FCTL) begin
                fctl_en_nxt = hwdata[FCTL_EN_BIT];
            end
            if (addr_r == ADDR_RX_TEST) begin
                m_rx_push = fae_r;
            end
        end
        if (bus_r == BUS_READ) begin
            hrdata_nxt = '0;
            unique case (addr_r)
                ADDR_FAR: hrdata_nxt[FAR_EN_BIT] = fae_r;
                ADDR_FCTL: hrdata_nxt[FCTL_EN_BIT] = fctl_en_r;
                // Upper status bits stay zero
                ADDR_USR: hrdata_nxt[USR_RFF_BIT] = rx_full;
                ADDR_TX_TEST: begin
                    if (fae_r && !tx_empty) begin
                        hrdata_nxt[DATA_W-1:0] = tx_head;
                        m_tx_pop = 1'b1;
                    end
                end
                default: hrdata_nxt = '0;
            endcase
        end
        if (accept) begin
            addr_nxt = haddr;
            bus_nxt = hwrite ? BUS_WRITE : BUS_READ;
            // One wait state lets a read see a write just before it
            hready_nxt = hwrite;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_r <= BUS_IDLE;
            addr_r <= '0;
            hready_r <= 1'b1;
            hrdata_r <= HRDATA_RESET;
            fae_r <= FAR_RESET;
            fctl_en_r <= FCTL_RESET;
        end else begin
            bus_r <= bus_nxt;
            addr_r <= addr_nxt;
            hready_r <= hready_nxt;
            hrdata_r <= hrdata_nxt;
            fae_r <= fae_nxt;
            fctl_en_r <= fctl_en_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = HRESP_OKAY;

    uft_change_det u_fae_det (
        .core_clk(core_clk),
        .rst(rst),
        .level(fae_r),
        .changed(fae_chg)
    );

    uft_change_det u_fctl_det (
        .core_clk(core_clk),
        .rst(rst),
        .level(fctl_en_r),
        .changed(fctl_chg)
    );

    // Switching either mode leaves stale pointers, so both sides restart
    assign clr = fae_chg || fctl_chg;

    // In test mode the master owns the rx fill and tx drain sides
    assign rx_push = fae_r ? m_rx_push : core_rx_push;
    assign rx_wdata = fae_r ? hwdata[DATA_W-1:0] : core_rx_data;
    assign rx_pop = core_rx_pop;
    assign tx_push = core_tx_push;
    assign tx_pop = fae_r ? m_tx_pop : core_tx_pop;

    uft_fifo u_rx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .clr(clr),
        .cap(cap),
        .push(rx_push),
        .wdata(rx_wdata),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count),
        .full(rx_full),
        .empty(rx_empty)
    );

    uft_fifo u_tx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .clr(clr),
        .cap(cap),
        .push(tx_push),
        .wdata(core_tx_data),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_count),
        .full(tx_full),
        .empty(tx_empty)
    );

    // Head copies lag the FIFO by one cycle
    always_comb begin
        rxh_nxt = rx_head;
        rxv_nxt = !rx_empty;
        txh_nxt = tx_head;
        txv_nxt = !tx_empty && !fae_r;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxh_r <= '0;
            rxv_r <= 1'b0;
            txh_r <= '0;
            txv_r <= 1'b0;
        end else begin
            rxh_r <= rxh_nxt;
            rxv_r <= rxv_nxt;
            txh_r <= txh_nxt;
            txv_r <= txv_nxt;
        end
    end

    assign rx_head_data = rxh_r;
    assign rx_head_valid = rxv_r;
    assign tx_head_data = txh_r;
    assign tx_head_valid = txv_r;
    assign fifo_enabled = fctl_en_r;
    assign test_access_active = fae_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence rd_addr_s;
        accept && !hwrite;
    endsequence
    sequence rd_wait_s;
        !hready_r ##1 hready_r;
    endsequence

    read_wait_state_a: assert property (rd_addr_s |=> rd_wait_s)
        else $error("read did not take exactly one wait state");

    far_locked_a: assert property (
        !FIFO_ACCESS |-> ##1 $stable(fae_r))
        else $error("enable bit changed without the option");

    rx_test_push_a: assert property (
        bus_r == BUS_WRITE && addr_r == ADDR_RX_TEST && fae_r && !rx_full
        && !clr && !rx_pop |=> rx_count == $past(rx_count) + 5'h01)
        else $error("test write did not append to rx");

    rx_test_off_a: assert property (
        !fae_r && !core_rx_push |=> rx_count <= $past(rx_count))
        else $error("rx filled while test access off");

    toggle_clear_a: assert property (
        $changed(fae_r) |=> rx_count == '0 && tx_count == '0)
        else $error("FIFOs not emptied after enable toggle");

    rff_read_a: assert property (
        bus_r == BUS_READ && addr_r == ADDR_USR
        |=> hrdata_r[USR_RFF_BIT] == $past(rx_count == cap))
        else $error("full status bit wrong");

    rff_self_clear_a: assert property (
        rx_full && rx_pop && !rx_push && !clr |=> !rx_full)
        else $error("full bit did not clear");

    usr_upper_zero_a: assert property (
        bus_r == BUS_READ && addr_r == ADDR_USR
        |=> hrdata_r[15:5] == '0)
        else $error("upper status bits not zero");

    holding_cap_a: assert property (
        !fctl_en_r && !$changed(fctl_en_r) |-> rx_count <= HOLD_CAP)
        else $error("holding register took more than one entry");

    depth_full_a: assert property (
        fctl_en_r && rx_count == FIFO_CAP |-> rx_full)
        else $error("rx not full at configured depth");

    tx_read_pop_a: assert property (
        bus_r == BUS_READ && addr_r == ADDR_TX_TEST && fae_r && !tx_empty
        && !clr && !core_tx_push
        |=> tx_count == $past(tx_count) - 5'h01 &&
        hrdata_r[DATA_W-1:0] == $past(tx_head))
        else $error("test read did not pop oldest tx entry");

    // Bus timing, mode switch and register readback checks
    write_no_wait_a: assert property (
        accept && hwrite |=> hready_r)
        else $error("write took a wait state");

    clear_wins_a: assert property (
        clr |=> rx_count == '0 && tx_count == '0)
        else $error("clear did not empty both FIFOs");

    far_read_a: assert property (
        bus_r == BUS_READ && addr_r == ADDR_FAR
        |=> hrdata_r[FAR_EN_BIT] == $past(fae_r))
        else $error("enable bit read back wrong");

    rff_clear_read_a: assert property (
        bus_r == BUS_READ && addr_r == ADDR_USR && !rx_full
        |=> !hrdata_r[USR_RFF_BIT])
        else $error("full bit set while rx not full");

    // Core side must not move the sides the master owns
    tx_pop_off_a: assert property (
        fae_r && !m_tx_pop && !core_tx_push && !clr
        |=> tx_count == $past(tx_count))
        else $error("core drained tx during test access");

    rx_push_off_a: assert property (
        fae_r && !m_rx_push && !rx_pop && !clr
        |=> rx_count == $past(rx_count))
        else $error("core filled rx during test access");

    tx_valid_masked_a: assert property (
        fae_r |=> !tx_head_valid)
        else $error("tx head shown valid in test access");

    sequence rx_test_wr_s;
        bus_r == BUS_WRITE && addr_r == ADDR_RX_TEST && fae_r;
    endsequence

    rx_hold_push_a: assert property (
        rx_test_wr_s ##0 (!fctl_en_r && rx_empty && !clr)
        |=> rx_count == HOLD_CAP && rx_head == $past(hwdata[DATA_W-1:0]))
        else $error("holding register not written by test write");
endmodule
`default_nettype wire

// ---- dv/uft_core_model.sv ----
// UART core stand-in that pushes and pops bytes on the FIFO side
`timescale 1ns/1ps
`default_nettype none
module uft_core_model (
    input wire logic core_clk,
    output logic core_rx_push,
    output logic [uft_pkg::DATA_W-1:0] core_rx_data,
    output logic core_rx_pop,
    output logic core_tx_push,
    output logic [uft_pkg::DATA_W-1:0] core_tx_data,
    output logic core_tx_pop
);
    import uft_pkg::*;
    initial begin
        core_rx_push = 1'b0;
        core_rx_data = 8'h00;
        core_rx_pop = 1'b0;
        core_tx_push = 1'b0;
        core_tx_data = 8'h00;
        core_tx_pop = 1'b0;
    end
    // The tx data line flips once the pulse ends so stale bytes never look valid
    task automatic push_tx(input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        core_tx_push <= 1'b1;
        core_tx_data <= d;
        @(posedge core_clk);
        core_tx_push <= 1'b0;
        core_tx_data <= ~d;
    endtask
    task automatic pop_rx();
        @(posedge core_clk);
        core_rx_pop <= 1'b1;
        @(posedge core_clk);
        core_rx_pop <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the FIFO test access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uft_pkg::*;
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rx_push, rx_pop, tx_push, tx_pop, rx_valid, tx_valid;
    logic fifo_en, test_on, lock_on;
    logic [DATA_W-1:0] rx_data, tx_data, rx_head, tx_head;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    uft_test_access #(.FIFO_ACCESS(1'b1)) dut_u (.core_clk(core_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .core_rx_push(rx_push), .core_rx_data(rx_data),
        .core_rx_pop(rx_pop), .rx_head_data(rx_head),
        .rx_head_valid(rx_valid), .core_tx_push(tx_push),
        .core_tx_data(tx_data), .core_tx_pop(tx_pop),
        .tx_head_data(tx_head), .tx_head_valid(tx_valid),
        .fifo_enabled(fifo_en), .test_access_active(test_on));
    // Copy built without the test option; its enable must never move
    uft_test_access #(.FIFO_ACCESS(1'b0)) dut_lock_u (.core_clk(core_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
        .core_rx_push(rx_push), .core_rx_data(rx_data),
        .core_rx_pop(rx_pop), .rx_head_data(), .rx_head_valid(),
        .core_tx_push(tx_push), .core_tx_data(tx_data),
        .core_tx_pop(tx_pop), .tx_head_data(), .tx_head_valid(),
        .fifo_enabled(), .test_access_active(lock_on));
    uft_core_model core_u (.core_clk(core_clk), .core_rx_push(rx_push),
        .core_rx_data(rx_data), .core_rx_pop(rx_pop),
        .core_tx_push(tx_push), .core_tx_data(tx_data),
        .core_tx_pop(tx_pop));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Single AHB transfer; waits on hreadyout in both phases
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic t_reset();
        bus(1'b0, ADDR_FAR, 32'h0);
        chk("far", rd, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b0, ADDR_USR, 32'h0);
        chk("usr", rd, 32'h0);
        bus(1'b0, 32'h5000_1190, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_fill();
        bus(1'b1, ADDR_FCTL, 32'h1);
        bus(1'b1, ADDR_FAR, 32'h1);
        bus(1'b0, ADDR_FAR, 32'h0);
        chk("far_on", rd, 32'h1);
        chk("fifo_en", {31'h0, fifo_en}, 32'h1);
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            bus(1'b0, ADDR_USR, 32'h0);
            chk("usr_fill", rd, 32'h0);
            bus(1'b1, ADDR_RX_TEST, 32'h0000_00a0 + i);
        end
        bus(1'b1, ADDR_RX_TEST, 32'h0000_00ff);
        bus(1'b0, ADDR_USR, 32'h0);
        chk("usr_full", rd, 32'h10);
        chk("rx_head", {24'h0, rx_head}, 32'ha0);
        core_u.pop_rx();
        repeat (2) @(posedge core_clk);
        chk("rx_next", {24'h0, rx_head}, 32'ha1);
        bus(1'b0, ADDR_USR, 32'h0);
        chk("usr_drop", rd, 32'h0);
    endtask
    task automatic t_toggle();
        bus(1'b1, ADDR_FAR, 32'h0);
        // Clear lands one cycle late, the head copy one more
        repeat (3) @(posedge core_clk);
        chk("rx_clear", {31'h0, rx_valid}, 32'h0);
        chk("test_off", {31'h0, test_on}, 32'h0);
        bus(1'b1, ADDR_RX_TEST, 32'h0000_0077);
        repeat (2) @(posedge core_clk);
        chk("rx_off", {31'h0, rx_valid}, 32'h0);
    endtask
    task automatic t_tx();
        core_u.push_tx(8'h11);
        repeat (2) @(posedge core_clk);
        chk("tx_valid", {31'h0, tx_valid}, 32'h1);
        chk("tx_head", {24'h0, tx_head}, 32'h11);
        bus(1'b1, ADDR_FAR, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("test_on", {31'h0, test_on}, 32'h1);
        chk("tx_masked", {31'h0, tx_valid}, 32'h0);
        chk("far_locked", {31'h0, lock_on}, 32'h0);
        bus(1'b0, ADDR_TX_TEST, 32'h0);
        chk("tx_clear", rd, 32'h0);
        core_u.push_tx(8'h33);
        core_u.push_tx(8'h44);
        bus(1'b0, ADDR_TX_TEST, 32'h0);
        chk("tx_first", rd, 32'h33);
        bus(1'b0, ADDR_TX_TEST, 32'h0);
        chk("tx_second", rd, 32'h44);
        bus(1'b0, ADDR_TX_TEST, 32'h0);
        chk("tx_empty", rd, 32'h0);
    endtask
    task automatic t_hold();
        bus(1'b1, ADDR_FCTL, 32'h0);
        repeat (2) @(posedge core_clk);
        bus(1'b1, ADDR_RX_TEST, 32'h0000_005a);
        bus(1'b0, ADDR_USR, 32'h0);
        chk("hold_full", rd, 32'h10);
        chk("hold_rx", {24'h0, rx_head}, 32'h5a);
        core_u.push_tx(8'h66);
        bus(1'b0, ADDR_TX_TEST, 32'h0);
        chk("hold_tx", rd, 32'h66);
    endtask
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_fill();
        t_toggle();
        t_tx();
        t_hold();
        close_out();
    end
endmodule
`default_nettype wire
